// ---- serial_port_modem_pins_tb.sv ----
`default_nettype none
// ----------
// bench
// ----------
module serial_port_modem_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic host_reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] lines = 4'h0;
  logic rx_low = 1'b0;
  logic [7:0] reg_rdata, rdata;
  logic [7:0] tx_val = 8'hA5;
  logic clk_en = 1'b1;
  logic irq, serial_rx_in, serial_tx_out, serial_tx_oe;
  logic request_to_send_n, request_to_send_n_oe;
  logic terminal_ready_n, terminal_ready_n_oe;
  logic data_set_ready_n, clear_to_send_n, ring_indicate_n;
  logic carrier_detect_n, strap_option_a, strap_option_b, strap_option_c;
  logic [7:0] ctl [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  int num_errors = 0;
  int cmp_count = 0;
  // released pins fall to their strap resistors: a=1, b=0, c=1
  wire logic serial_tx_in = serial_tx_oe ? serial_tx_out : 1'b1;
  wire logic request_to_send_n_in =
    request_to_send_n_oe ? request_to_send_n : 1'b0;
  wire logic terminal_ready_n_in =
    terminal_ready_n_oe ? terminal_ready_n : 1'b1;
  always #10 clock = ~clock;
  spmp_top i_dut (
    .clock, .nrst, .clk_en, .host_reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .serial_rx_in, .serial_tx_in,
    .serial_tx_out, .serial_tx_oe, .request_to_send_n_in,
    .request_to_send_n, .request_to_send_n_oe, .terminal_ready_n_in,
    .terminal_ready_n, .terminal_ready_n_oe, .data_set_ready_n,
    .clear_to_send_n, .ring_indicate_n, .carrier_detect_n,
    .strap_option_a, .strap_option_b, .strap_option_c
  );
  spmp_modem i_modem (
    .clock, .assert_lines(lines), .rx_low, .clear_to_send_n,
    .data_set_ready_n, .ring_indicate_n, .carrier_detect_n, .serial_rx_in
  );
  // bus cycles: strobes rise and fall right after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  // read data is valid in the one cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rdata = reg_rdata;
    cmp_byte(rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run is near 300 cycles, so this only trips on a hang
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    tick(3);
    cmp_bit(serial_tx_oe, 1'b0);
    cmp_byte({5'h0, strap_option_c, strap_option_b, strap_option_a},
      8'h05);
    @(posedge clock);
    host_reset_n <= 1'b1;
    tick(2);
    cmp_byte({serial_tx_oe, request_to_send_n_oe, terminal_ready_n_oe,
      serial_tx_out, request_to_send_n, terminal_ready_n, 2'b00},
      8'hFC);
    cmp_byte({5'h0, strap_option_c, strap_option_b, strap_option_a},
      8'h05);
    rd_chk(spmp_pkg::A_LINE_STAT, 8'h0D);
    rd_chk(spmp_pkg::A_MODEM_STAT, 8'h00);
    rd_chk(spmp_pkg::A_MODEM_CTRL, 8'h00);
    rd_chk(spmp_pkg::A_DIV_LO, 8'hB2);
    rd_chk(spmp_pkg::A_DIV_HI, 8'h01);
    rd_chk(spmp_pkg::A_INT_MASK, 8'h00);
    wr(4'h9, 8'hFF);
    for (int a = 9; a < 16; a++) rd_chk(a[3:0], 8'h00);
    foreach (ctl[i]) begin
      wr(spmp_pkg::A_MODEM_CTRL, ctl[i]);
      tick(2);
      cmp_byte({request_to_send_n, terminal_ready_n},
        {~ctl[i][1], ~ctl[i][0]});
    end
    // a write while the enable is low must leave control untouched
    @(posedge clock);
    clk_en <= 1'b0;
    wr(spmp_pkg::A_MODEM_CTRL, 8'h03);
    clk_en <= 1'b1;
    rd_chk(spmp_pkg::A_MODEM_CTRL, 8'h00);
    cmp_byte({request_to_send_n, terminal_ready_n}, 8'h03);
    // loop mode: pins stay inactive, status mirrors control bits
    wr(spmp_pkg::A_MODEM_CTRL, 8'h1F);
    tick(2);
    cmp_byte({serial_tx_out, request_to_send_n, terminal_ready_n},
      8'h07);
    rd_chk(spmp_pkg::A_MODEM_STAT, 8'hF0);
    wr(spmp_pkg::A_MODEM_CTRL, 8'h15);
    tick(2);
    cmp_byte({request_to_send_n, terminal_ready_n}, 8'h03);
    rd_chk(spmp_pkg::A_MODEM_STAT, 8'h60);
    wr(spmp_pkg::A_MODEM_CTRL, 8'h00);
    tick(4);
    wr(spmp_pkg::A_INT_STAT, 8'h3F);
    wr(spmp_pkg::A_INT_MASK, 8'h3F);
    tick(2);
    cmp_bit(irq, 1'b0);
    // each modem line: status level, sticky change bit, irq
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      lines <= 4'h1 << i;
      tick(4);
      cmp_bit(irq, 1'b1);
      rd_chk(spmp_pkg::A_MODEM_STAT, 8'h10 << i);
      rd_chk(spmp_pkg::A_INT_STAT, 8'h01 << i);
      @(posedge clock);
      lines <= 4'h0;
      tick(4);
      wr(spmp_pkg::A_INT_STAT, 8'h3F);
      tick(2);
      cmp_bit(irq, 1'b0);
    end
    wr(spmp_pkg::A_INT_MASK, 8'h3E);
    @(posedge clock);
    lines <= 4'h1;
    tick(4);
    cmp_bit(irq, 1'b0);
    rd_chk(spmp_pkg::A_INT_STAT, 8'h01);
    @(posedge clock);
    lines <= 4'h0;
    rx_low <= 1'b1;
    tick(4);
    rd_chk(spmp_pkg::A_LINE_STAT, 8'h05);
    rd_chk(spmp_pkg::A_INT_STAT, 8'h11);
    @(posedge clock);
    rx_low <= 1'b0;
    tick(4);
    wr(spmp_pkg::A_INT_STAT, 8'h3F);
    wr(spmp_pkg::A_INT_MASK, 8'h3F);
    // one frame, two clocks a bit, lsb first
    wr(spmp_pkg::A_DIV_LO, 8'h02);
    wr(spmp_pkg::A_DIV_HI, 8'h00);
    cmp_bit(serial_tx_out, 1'b1);
    wr(spmp_pkg::A_TX_DATA, tx_val);
    for (int n = 0; n < 20 && serial_tx_out; n++) tick(1);
    cmp_bit(serial_tx_out, 1'b0);
    for (int k = 0; k < 8; k++) begin
      tick(2);
      cmp_bit(serial_tx_out, tx_val[k]);
    end
    tick(2);
    cmp_bit(serial_tx_out, 1'b1);
    tick(6);
    rd_chk(spmp_pkg::A_INT_STAT, 8'h20);
    cmp_bit(irq, 1'b1);
    wr(spmp_pkg::A_INT_STAT, 8'h3F);
    // infrared mode keeps the wired pin marking through a frame
    wr(spmp_pkg::A_MODE, 8'h01);
    wr(spmp_pkg::A_TX_DATA, 8'h00);
    for (int n = 0; n < 30; n++) begin
      tick(1);
      cmp_bit(serial_tx_out, 1'b1);
    end
    wr(spmp_pkg::A_MODE, 8'h00);
    tick(4);
    end_sim();
  end
endmodule // serial_port_modem_pins_tb
`default_nettype wire

// ---- spmp_if.sv ----
`default_nettype none
// one sampled modem or receive line
interface spmp_line_if;
  logic raw;
  logic level;
  logic change;
  modport det (input raw, output level, output change);
  modport user (output raw, input level, input change);
endinterface

// character transmitter hookup
interface spmp_tx_if #(parameter int DIV_W = 16);
  logic start;
  logic [7:0] data;
  logic [DIV_W-1:0] divisor;
  logic busy;
  logic line;
  logic done;
  modport tx (input start, input data, input divisor,
              output busy, output line, output done);
  modport user (output start, output data, output divisor,
                input busy, input line, input done);
endinterface
`default_nettype wire

// ---- spmp_line_sense.sv ----
`default_nettype none
module spmp_line_sense #(
  parameter logic RST_LEVEL = 1'b1 // idle level of the line
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset
  input wire logic clk_en, // state freeze when low
  spmp_line_if.det line // raw in, level and change out
);
  logic level_q;
  logic change_q;

  // ----------------------------------------
  // sample and change detect
  // ----------------------------------------
  // inputs are synchronous, so one stage suffices
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_q <= RST_LEVEL;
      change_q <= 1'b0;
    end else if (clk_en) begin
      level_q <= line.raw;
      change_q <= line.raw ^ level_q;
    end
  end

  assign line.level = level_q;
  assign line.change = change_q;
endmodule // spmp_line_sense
`default_nettype wire

// ---- spmp_modem.sv ----
`default_nettype none
// ----------
// modem model
// ----------
module spmp_modem (
  input wire logic clock, // clk
  input wire logic [3:0] assert_lines, // cts dsr ri dcd requests
  input wire logic rx_low, // hold receive line at space
  output logic clear_to_send_n, // cts
  output logic data_set_ready_n, // dsr
  output logic ring_indicate_n, // ri
  output logic carrier_detect_n, // dcd
  output logic serial_rx_in // receive line
);
  timeunit 1ns;
  timeprecision 1ns;
  // levels move only after an edge, as a line driver would; the
  // first edge comes well inside the master reset
  always @(posedge clock) begin
    clear_to_send_n <= !assert_lines[0];
    data_set_ready_n <= !assert_lines[1];
    ring_indicate_n <= !assert_lines[2];
    carrier_detect_n <= !assert_lines[3];
    serial_rx_in <= !rx_low;
  end
endmodule // spmp_modem
`default_nettype wire

// ---- spmp_monitor.sv ----
`default_nettype none
// ----------
// pin checker
// ----------
module spmp_monitor (
  input wire logic clock, // clk
  input wire logic nrst, // reset
  input wire logic clk_en, // run
  input wire logic host_reset_n, // host reset
  input wire logic [3:0] reg_addr, // index
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic serial_tx_in, // tx pin
  input wire logic serial_tx_out, // tx drive
  input wire logic serial_tx_oe, // tx enable
  input wire logic request_to_send_n_in, // rts pin
  input wire logic request_to_send_n, // rts
  input wire logic terminal_ready_n_in, // dtr pin
  input wire logic terminal_ready_n, // dtr
  input wire logic data_set_ready_n, // dsr
  input wire logic clear_to_send_n, // cts
  input wire logic ring_indicate_n, // ri
  input wire logic carrier_detect_n, // dcd
  input wire logic strap_option_a, // strap a
  input wire logic strap_option_b, // strap b
  input wire logic strap_option_c // strap c
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic loop_q;
  wire logic rts_bit = reg_wdata[spmp_pkg::MC_RTS];
  wire logic dtr_bit = reg_wdata[spmp_pkg::MC_DTR];
  // loop shadow: status sources move while it is set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) loop_q <= 1'b0;
    else if (clk_en && reg_wr && reg_addr == spmp_pkg::A_MODEM_CTRL)
      loop_q <= reg_wdata[spmp_pkg::MC_LOOP];
  end
  sequence s_ctrl_wr(lp);
    clk_en && reg_wr && reg_addr == spmp_pkg::A_MODEM_CTRL
      && reg_wdata[spmp_pkg::MC_LOOP] == lp ##1 clk_en;
  endsequence
  sequence s_ir_on;
    clk_en && reg_wr && reg_addr == spmp_pkg::A_MODE
      && reg_wdata[spmp_pkg::MODE_IR];
  endsequence
  chk_reset_marks: assert property (
    !$past(nrst) |-> serial_tx_out && request_to_send_n && terminal_ready_n)
    else $error("outputs not idle after reset");
  chk_host_oe_off: assert property (
    clk_en && !host_reset_n |=> !serial_tx_oe)
    else $error("tx enable high in host reset");
  chk_host_oe_on: assert property (
    clk_en && host_reset_n |=> serial_tx_oe)
    else $error("tx enable low after host reset");
  chk_strap_take: assert property (
    clk_en && !host_reset_n |=> {strap_option_c, strap_option_b,
      strap_option_a} == $past({serial_tx_in, request_to_send_n_in,
      terminal_ready_n_in}))
    else $error("strap not sampled");
  chk_strap_keep: assert property (
    host_reset_n |=>
      $stable({strap_option_a, strap_option_b, strap_option_c}))
    else $error("strap moved after host reset");
  chk_ctrl_follow: assert property (
    s_ctrl_wr(1'b0) |=> request_to_send_n == !$past(rts_bit, 2)
      && terminal_ready_n == !$past(dtr_bit, 2))
    else $error("control pins wrong");
  chk_loop_quiet: assert property (
    s_ctrl_wr(1'b1) |=>
      (request_to_send_n && terminal_ready_n && serial_tx_out) [*2])
    else $error("pins active in loop");
  chk_ir_mark: assert property (
    s_ir_on |-> ##3 serial_tx_out [*8])
    else $error("tx left marking in infrared");
  chk_status_view: assert property (
    clk_en && reg_rd && reg_addr == spmp_pkg::A_MODEM_STAT && !loop_q
      && !$past(loop_q) |=> reg_rdata == {~$past(carrier_detect_n, 2),
      ~$past(ring_indicate_n, 2), ~$past(data_set_ready_n, 2),
      ~$past(clear_to_send_n, 2), 4'h0})
    else $error("modem status wrong");
endmodule // spmp_monitor

bind spmp_top spmp_monitor i_mon (
  .clock, .nrst, .clk_en, .host_reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .serial_tx_in, .serial_tx_out, .serial_tx_oe,
  .request_to_send_n_in, .request_to_send_n, .terminal_ready_n_in,
  .terminal_ready_n, .data_set_ready_n, .clear_to_send_n,
  .ring_indicate_n, .carrier_detect_n, .strap_option_a, .strap_option_b,
  .strap_option_c
);
`default_nettype wire

// ---- spmp_pkg.sv ----
`default_nettype none
package spmp_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [3:0] A_MODEM_CTRL = 4'h0;
  localparam logic [3:0] A_MODEM_STAT = 4'h1;
  localparam logic [3:0] A_MODE = 4'h2;
  localparam logic [3:0] A_TX_DATA = 4'h3;
  localparam logic [3:0] A_DIV_LO = 4'h4;
  localparam logic [3:0] A_DIV_HI = 4'h5;
  localparam logic [3:0] A_INT_STAT = 4'h6;
  localparam logic [3:0] A_INT_MASK = 4'h7;
  localparam logic [3:0] A_LINE_STAT = 4'h8;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int MC_W = 5;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MS_SHIFT = 4;
  localparam int MODE_IR = 0;
  localparam int EV_N = 6;
  localparam int LN_CTS = 0;
  localparam int LN_DSR = 1;
  localparam int LN_RI = 2;
  localparam int LN_DCD = 3;
  localparam int LN_RX = 4;
  localparam int LN_N = 5;
  localparam int STRAP_N = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [MC_W-1:0] MC_RST = 5'h00;
  localparam logic [EV_N-1:0] EV_RST = 6'h00;
  localparam logic [STRAP_N-1:0] STRAP_RST = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h01B2;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } spmp_tx_state_t;
endpackage
`default_nettype wire

// ---- spmp_top.sv ----
// Our own choices: the register offsets and strobed register access.
`default_nettype none
module spmp_top #(
  parameter logic [15:0] DIV_RST = spmp_pkg::DIV_RST // reset bit time
) (
  input wire logic clock, // system clock
  input wire logic nrst, // master reset
  input wire logic clk_en, // freezes all state
  input wire logic host_reset_n, // host bus reset
  input wire logic [spmp_pkg::ADDR_W-1:0] reg_addr, // index
  input wire logic [spmp_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [spmp_pkg::DATA_W-1:0] reg_rdata, // read data
  output logic irq, // interrupt level
  input wire logic serial_rx_in, // receive line
  input wire logic serial_tx_in, // transmit pin level
  output logic serial_tx_out, // transmit drive
  output logic serial_tx_oe, // transmit enable
  input wire logic request_to_send_n_in, // rts pin level
  output logic request_to_send_n, // rts drive
  output logic request_to_send_n_oe, // rts enable
  input wire logic terminal_ready_n_in, // dtr pin level
  output logic terminal_ready_n, // dtr drive
  output logic terminal_ready_n_oe, // dtr enable
  input wire logic data_set_ready_n, // modem ready
  input wire logic clear_to_send_n, // modem accepts data
  input wire logic ring_indicate_n, // ring seen
  input wire logic carrier_detect_n, // carrier seen
  output logic strap_option_a, // strap from dtr pin
  output logic strap_option_b, // strap from rts pin
  output logic strap_option_c // strap from tx pin
);
  localparam int DW = spmp_pkg::DATA_W;
  localparam int EN = spmp_pkg::EV_N;
  localparam int MW = spmp_pkg::MC_W;

  generate
    if (DIV_RST == 16'h0000) begin : g_chk
      $error("spmp_top: DIV_RST must be non-zero");
    end
  endgenerate

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [MW-1:0] mc_q;
  logic ir_q;
  logic [spmp_pkg::DIV_W-1:0] div_q;
  logic [EN-1:0] ist_q;
  logic [EN-1:0] ist_d;
  logic [EN-1:0] imask_q;
  logic [spmp_pkg::STRAP_N-1:0] strap_q;
  logic [DW-1:0] rdata_q;
  logic irq_q;
  logic tx_q;
  logic rts_q;
  logic dtr_q;
  logic pin_oe_q;
  logic tx_start_q;
  logic [DW-1:0] tx_byte_q;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wr_mc;
  logic wr_mode;
  logic wr_tx;
  logic wr_dlo;
  logic wr_dhi;
  logic wr_ist;
  logic wr_imask;
  assign wr_mc = reg_wr && (reg_addr == spmp_pkg::A_MODEM_CTRL);
  assign wr_mode = reg_wr && (reg_addr == spmp_pkg::A_MODE);
  assign wr_tx = reg_wr && (reg_addr == spmp_pkg::A_TX_DATA);
  assign wr_dlo = reg_wr && (reg_addr == spmp_pkg::A_DIV_LO);
  assign wr_dhi = reg_wr && (reg_addr == spmp_pkg::A_DIV_HI);
  assign wr_ist = reg_wr && (reg_addr == spmp_pkg::A_INT_STAT);
  assign wr_imask = reg_wr && (reg_addr == spmp_pkg::A_INT_MASK);

  // control fields
  logic loop_on;
  logic ir_on;
  assign loop_on = mc_q[spmp_pkg::MC_LOOP];
  assign ir_on = ir_q;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  spmp_tx_if #(.DIV_W(spmp_pkg::DIV_W)) txp ();

  assign txp.start = tx_start_q;
  assign txp.data = tx_byte_q;
  assign txp.divisor = div_q;

  spmp_tx_serial #(.DIV_W(spmp_pkg::DIV_W)) u_tx (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .txp(txp)
  );

  // ----------------------------------------
  // line sampling
  // ----------------------------------------
  spmp_line_if lines [spmp_pkg::LN_N] ();

  // loop mode turns the control bits back onto the status inputs
  assign lines[spmp_pkg::LN_CTS].raw =
    loop_on ? !mc_q[spmp_pkg::MC_RTS] : clear_to_send_n;
  assign lines[spmp_pkg::LN_DSR].raw =
    loop_on ? !mc_q[spmp_pkg::MC_DTR] : data_set_ready_n;
  assign lines[spmp_pkg::LN_RI].raw =
    loop_on ? !mc_q[spmp_pkg::MC_AUX1] : ring_indicate_n;
  assign lines[spmp_pkg::LN_DCD].raw =
    loop_on ? !mc_q[spmp_pkg::MC_AUX2] : carrier_detect_n;
  // receive path, fed from the transmitter in loop mode
  assign lines[spmp_pkg::LN_RX].raw =
    loop_on ? txp.line : serial_rx_in;

  logic [spmp_pkg::LN_N-1:0] ln_level;
  logic [spmp_pkg::LN_N-1:0] ln_change;

  genvar gi;
  generate
    for (gi = 0; gi < spmp_pkg::LN_N; gi++) begin : g_line
      spmp_line_sense #(.RST_LEVEL(1'b1)) u_sense (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .line(lines[gi])
      );
      assign ln_level[gi] = lines[gi].level;
      assign ln_change[gi] = lines[gi].change;
    end
  endgenerate

  // ----------------------------------------
  // events and status
  // ----------------------------------------
  logic rx_start_ev;
  logic [EN-1:0] events;
  logic [EN-1:0] ist_clr;
  // a falling receive line marks a possible start bit
  assign rx_start_ev = ln_change[spmp_pkg::LN_RX] &&
                       !ln_level[spmp_pkg::LN_RX];
  assign events = {txp.done, rx_start_ev,
                   ln_change[spmp_pkg::LN_DCD:spmp_pkg::LN_CTS]};
  assign ist_clr = wr_ist ? reg_wdata[EN-1:0] : '0;
  // set beats clear so an event in the clearing cycle survives
  assign ist_d = (ist_q & ~ist_clr) | events;

  // modem status, shown as asserted-high
  logic [3:0] ms_now;
  assign ms_now = ~ln_level[spmp_pkg::LN_DCD:spmp_pkg::LN_CTS];

  // ----------------------------------------
  // read selection
  // ----------------------------------------
  logic [DW-1:0] rd_mc;
  logic [DW-1:0] rd_ms;
  logic [DW-1:0] rd_mode;
  logic [DW-1:0] rd_dlo;
  logic [DW-1:0] rd_dhi;
  logic [DW-1:0] rd_ist;
  logic [DW-1:0] rd_imask;
  logic [DW-1:0] rd_line;
  logic [DW-1:0] rd_mux;
  assign rd_mc = {{(DW - MW){1'b0}}, mc_q};
  // cts, dsr, ri and dcd in the upper nibble
  assign rd_ms = {ms_now, 4'h0};
  assign rd_mode = {{(DW - 1){1'b0}}, ir_q};
  assign rd_dlo = div_q[DW-1:0];
  assign rd_dhi = div_q[spmp_pkg::DIV_W-1:DW];
  assign rd_ist = {{(DW - EN){1'b0}}, ist_q};
  assign rd_imask = {{(DW - EN){1'b0}}, imask_q};
  // straps, receive level and transmitter busy
  assign rd_line = {3'h0, txp.busy, ln_level[spmp_pkg::LN_RX],
                    strap_q};
  // unmapped indices, including the data port, read as zero
  assign rd_mux =
    (reg_addr == spmp_pkg::A_MODEM_CTRL) ? rd_mc :
    (reg_addr == spmp_pkg::A_MODEM_STAT) ? rd_ms :
    (reg_addr == spmp_pkg::A_MODE) ? rd_mode :
    (reg_addr == spmp_pkg::A_DIV_LO) ? rd_dlo :
    (reg_addr == spmp_pkg::A_DIV_HI) ? rd_dhi :
    (reg_addr == spmp_pkg::A_INT_STAT) ? rd_ist :
    (reg_addr == spmp_pkg::A_INT_MASK) ? rd_imask :
    (reg_addr == spmp_pkg::A_LINE_STAT) ? rd_line : '0;

  // ----------------------------------------
  // pin drive values
  // ----------------------------------------
  logic tx_d;
  logic rts_d;
  logic dtr_d;
  // infrared or loop keeps the wired line marking
  assign tx_d = (ir_on || loop_on) ? 1'b1 : txp.line;
  // control bit one drives the pin low, loop forces inactive
  assign rts_d = loop_on || !mc_q[spmp_pkg::MC_RTS];
  assign dtr_d = loop_on || !mc_q[spmp_pkg::MC_DTR];

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // master reset clears control, so rts and dtr start high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mc_q <= spmp_pkg::MC_RST;
      ir_q <= 1'b0;
      div_q <= DIV_RST;
      imask_q <= spmp_pkg::EV_RST;
    end else if (clk_en) begin
      if (wr_mc) mc_q <= reg_wdata[MW-1:0];
      if (wr_mode) ir_q <= reg_wdata[spmp_pkg::MODE_IR];
      if (wr_dlo) div_q[DW-1:0] <= reg_wdata;
      if (wr_dhi) div_q[spmp_pkg::DIV_W-1:DW] <= reg_wdata;
      if (wr_imask) imask_q <= reg_wdata[EN-1:0];
    end
  end

  // divisor reload is not needed: DIV_RST only sets the default
  // a write to the data port while busy is dropped, not queued
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_start_q <= 1'b0;
      tx_byte_q <= spmp_pkg::BYTE_RST;
    end else if (clk_en) begin
      tx_start_q <= wr_tx && !txp.busy && !tx_start_q;
      if (wr_tx) tx_byte_q <= reg_wdata;
    end
  end

  // sticky status and the interrupt level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ist_q <= spmp_pkg::EV_RST;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      ist_q <= ist_d;
      irq_q <= |(ist_d & imask_q);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= spmp_pkg::BYTE_RST;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rd_mux : spmp_pkg::BYTE_RST;
    end
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // pins are sampled every cycle of the host reset; the last
  // sample before release is what stays latched afterwards
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_q <= spmp_pkg::STRAP_RST;
    end else if (clk_en && !host_reset_n) begin
      strap_q <= {serial_tx_in,
                  request_to_send_n_in,
                  terminal_ready_n_in};
    end
  end

  // ----------------------------------------
  // pin registers
  // ----------------------------------------
  // enables stay off under host reset so a strap that is being
  // read at the same time is never fought; drive returns one edge
  // after the host reset lifts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_oe_q <= 1'b0;
      tx_q <= 1'b1;
      rts_q <= 1'b1;
      dtr_q <= 1'b1;
    end else if (clk_en) begin
      pin_oe_q <= host_reset_n;
      tx_q <= tx_d;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign serial_tx_out = tx_q;
  assign serial_tx_oe = pin_oe_q;
  assign request_to_send_n = rts_q;
  assign request_to_send_n_oe = pin_oe_q;
  assign terminal_ready_n = dtr_q;
  assign terminal_ready_n_oe = pin_oe_q;
  assign strap_option_a = strap_q[0];
  assign strap_option_b = strap_q[1];
  assign strap_option_c = strap_q[2];
endmodule // spmp_top
`default_nettype wire

// ---- spmp_tx_serial.sv ----
`default_nettype none
module spmp_tx_serial #(
  parameter int DIV_W = 16 // divisor width
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset
  input wire logic clk_en, // state freeze when low
  spmp_tx_if.tx txp // character in, serial line out
);
  spmp_pkg::spmp_tx_state_t st_q;
  spmp_pkg::spmp_tx_state_t st_d;
  logic [DIV_W-1:0] cnt_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic done_q;
  logic [DIV_W-1:0] lim;
  logic tick;
  logic idle;

  generate
    if (DIV_W < 2) begin : g_chk
      $error("spmp_tx_serial: DIV_W must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  // a zero divisor runs at one bit per cycle
  assign lim = (txp.divisor == '0) ? '0 : txp.divisor - 1'b1;
  assign idle = (st_q == spmp_pkg::TX_IDLE);
  assign tick = !idle && (cnt_q >= lim);

  // frame sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      spmp_pkg::TX_IDLE: if (txp.start) st_d = spmp_pkg::TX_START;
      spmp_pkg::TX_START: if (tick) st_d = spmp_pkg::TX_DATA;
      spmp_pkg::TX_DATA: begin
        if (tick && bit_q == spmp_pkg::LAST_BIT) begin
          st_d = spmp_pkg::TX_STOP;
        end
      end
      spmp_pkg::TX_STOP: if (tick) st_d = spmp_pkg::TX_IDLE;
      default: st_d = spmp_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= spmp_pkg::TX_IDLE;
      cnt_q <= '0;
      sh_q <= spmp_pkg::BYTE_RST;
      bit_q <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= (tick || idle) ? '0 : cnt_q + 1'b1;
      if (idle && txp.start) sh_q <= txp.data;
      else if (tick && st_q == spmp_pkg::TX_DATA) sh_q <= sh_q >> 1;
      if (st_q != spmp_pkg::TX_DATA) bit_q <= '0;
      else if (tick) bit_q <= bit_q + 1'b1;
      done_q <= tick && (st_q == spmp_pkg::TX_STOP);
    end
  end

  // lsb first, start bit low, stop and idle marking
  assign txp.line = (st_q == spmp_pkg::TX_START) ? 1'b0 :
                    (st_q == spmp_pkg::TX_DATA) ? sh_q[0] : 1'b1;
  assign txp.busy = !idle;
  assign txp.done = done_q;
endmodule // spmp_tx_serial
`default_nettype wire
